/* pkg/frame_energy_map.svh */
/*
 * Constants for the frame energy and pole tone test: lag counts,
 * field positions, widths and the low-frequency ratio limit.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef FRAME_ENERGY_MAP_SVH
`define FRAME_ENERGY_MAP_SVH

// ==========================================================
// frame shape
`define FILTER_ORDER 8
`define NUM_LAGS 9
`define LAST_LAG 4'h8
`define LAG_END 4'h9
`define FRAME_MS 20
`define FRAME_LAST_SAMPLE 167

// ==========================================================
// lag word layout in the coefficient store
`define SIG_ACF_MSB 31
`define SIG_ACF_LSB 16
`define FLT_ACF_MSB 15
`define FLT_ACF_LSB 0

// ==========================================================
// widths and fixed-point scaling
`define DATA_W 16
`define WORD_W 32
`define ACC_W 40
`define Q_FRAC 15

// 0.0973 in Q15, tan^2 of the 385 Hz pole angle
`define LOW_RATIO_Q15 54'sh0c74

// ==========================================================
// reset values
`define ACC_RESET 40'sh0
`define CNT_RESET 4'h0

`endif

/* pkg/frame_energy_pkg.sv */
/*
 * Types shared by the frame energy and pole tone test files.
 * Assumes frame_energy_map.svh is on the include path.
 */
`include "frame_energy_map.svh"

package frame_energy_pkg;

    // ==========================================================
    // control states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE
    } state_e;

    typedef logic signed [`DATA_W-1:0] sample_t;
    typedef logic [`WORD_W-1:0] lag_word_t;
    typedef logic signed [`ACC_W-1:0] acc_t;
    typedef logic [3:0] lag_idx_t;

endpackage : frame_energy_pkg

/* hdl/coef_store.sv */
/*
 * Nine-word store of lag pairs (signal and filter autocorrelation).
 * Assumes one writer and one reader on core_clk; read data registered.
 */
`timescale 1ns/100ps

module coef_store
    import frame_energy_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire lag_idx_t wr_addr,
    input wire lag_word_t wr_data,
    input wire lag_idx_t rd_addr,
    output lag_word_t rd_data
);

    lag_word_t mem [`NUM_LAGS];

    // ==========================================================
    // write port, no reset on contents
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read; index beyond the last lag reads zero
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_data <= '0;
        end else if (rd_addr <= `LAST_LAG) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end

endmodule : coef_store

/* hdl/frame_energy_and_pole_tone_test.sv */
/*
 * Frame energy of the block-filtered speech frame and second-order
 * pole tone test, one pass per frame.
 * Assumes the encoder drives all inputs on core_clk, loads the nine
 * lag pairs while idle and then pulses frame_start once per frame.
 */
// Summary of operation
// - output is negated 8th-order tap sum
// - per-frame block filter, no earlier history
// - energy is lag0 product plus twice rest
// - pole filter from first two reflection coefficients
// - real is -a1/2, imag (4a2-a1^2)/4
// - negative imag term means not a tone
// - negative real part needs prediction-error test
// - both non-negative: compare ratio against 0.0973
// - low ratio passes means not a tone
`timescale 1ns/100ps

module frame_energy_and_pole_tone_test
    import frame_energy_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic lag_load,
    input wire lag_idx_t lag_index,
    input wire sample_t signal_acf,
    input wire sample_t filter_acf,
    input wire logic frame_start,
    input wire sample_t reflection_coefficient_1,
    input wire sample_t reflection_coefficient_2,
    output logic busy,
    output logic result_valid,
    output acc_t frame_energy,
    output logic not_tone,
    output logic pe_test_required,
    output logic signed [17:0] pole_real_part,
    output logic signed [37:0] pole_imag_term
);

    // ==========================================================
    // helpers
    function automatic logic signed [31:0] prod16(input sample_t a,
                                                  input sample_t b);
        prod16 = a * b;
    endfunction : prod16

    state_e state_reg, state_next;
    lag_idx_t cnt_reg, cnt_next;
    logic pend_reg, pend_next;
    logic lag0_reg;
    acc_t acc_reg;
    sample_t k1_reg, k2_reg;
    lag_word_t rd_data;

    // ==========================================================
    // request acceptance; both refused while a frame runs
    logic idle_w, start_take, load_take;
    assign idle_w = (state_reg == ST_IDLE);
    assign start_take = frame_start && idle_w;
    assign load_take = lag_load && idle_w && (lag_index <= `LAST_LAG);

    coef_store u_store (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(load_take),
        .wr_addr(lag_index),
        .wr_data({signal_acf, filter_acf}),
        .rd_addr(cnt_reg),
        .rd_data(rd_data)
    );

    // ==========================================================
    // lag walk control
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_take) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pend_reg && cnt_reg == `LAG_END) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // counter addresses the store; data follows one cycle later
    assign cnt_next = (state_reg != ST_RUN) ? `CNT_RESET :
                      (cnt_reg < `LAG_END) ? cnt_reg + 4'h1 : cnt_reg;
    assign pend_next = (state_reg == ST_RUN) && (cnt_reg <= `LAST_LAG);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `CNT_RESET;
            pend_reg <= 1'b0;
            lag0_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            lag0_reg <= (cnt_reg == `CNT_RESET);
        end
    end

    // ==========================================================
    // energy accumulation
    // the lag pairs already hold the 8th-order tap sum over samples
    // 0..167 with taps cut at min(8,n), so the energy needs only the
    // nine products instead of re-filtering the frame
    logic signed [31:0] lag_prod;
    acc_t lag_term;
    assign lag_prod = prod16(rd_data[`SIG_ACF_MSB:`SIG_ACF_LSB],
                             rd_data[`FLT_ACF_MSB:`FLT_ACF_LSB]);
    assign lag_term = lag0_reg ? `ACC_W'(lag_prod) :
                      (`ACC_W'(lag_prod) <<< 1);

    // negated tap sum enters via products
    always_ff @(posedge core_clk) begin
        if (!nrst || start_take) begin
            acc_reg <= `ACC_RESET;
        end else if (pend_reg) begin
            acc_reg <= acc_reg + lag_term;
        end
    end

    // reflection coefficients held for the whole frame
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            k1_reg <= '0;
            k2_reg <= '0;
        end else if (start_take) begin
            k1_reg <= reflection_coefficient_1;
            k2_reg <= reflection_coefficient_2;
        end
    end

    // ==========================================================
    // pole test arithmetic, Q15 coefficients, Q30 squares
    logic signed [32:0] a1_q30;
    logic signed [17:0] a1_w, real_w;
    logic signed [35:0] a1sq_w;
    logic signed [37:0] num_w, imag_w;
    logic signed [53:0] lhs_w, rhs_w;
    logic imag_neg, real_neg, low_ratio;

    // a0 = 1, a1 = k1(1+k2), a2 = k2
    assign a1_q30 = (33'(k1_reg) <<< `Q_FRAC) +
                    33'(prod16(k1_reg, k2_reg));
    assign a1_w = a1_q30[32:15];
    assign a1sq_w = a1_w * a1_w;
    assign real_w = -(a1_w >>> 1);
    assign num_w = (38'(k2_reg) <<< 17) - 38'(a1sq_w);
    assign imag_w = num_w >>> 2;
    assign imag_neg = num_w[37];
    assign real_neg = real_w[17];
    assign lhs_w = 54'(num_w) <<< `Q_FRAC;
    assign rhs_w = `LOW_RATIO_Q15 * 54'(a1sq_w);
    assign low_ratio = (lhs_w < rhs_w);

    // ==========================================================
    // registered results, all outputs from flops
    logic not_tone_next;
    // low ratio with a non-negative real part means not a tone
    assign not_tone_next = imag_neg || (!real_neg && low_ratio);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busy <= 1'b0;
            result_valid <= 1'b0;
            frame_energy <= `ACC_RESET;
            not_tone <= 1'b0;
            pe_test_required <= 1'b0;
            pole_real_part <= '0;
            pole_imag_term <= '0;
        end else begin
            busy <= (state_next != ST_IDLE);
            result_valid <= (state_reg == ST_DONE);
            if (state_reg == ST_DONE) begin
                frame_energy <= acc_reg;
                not_tone <= not_tone_next;
                pe_test_required <= !not_tone_next;
                pole_real_part <= real_w;
                pole_imag_term <= imag_w;
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_take;
        start_take;
    endsequence

    sequence s_result;
        result_valid && (not_tone ^ pe_test_required);
    endsequence

    // nine products: eight, the ninth, then the walk stops
    sequence s_walk;
        pend_reg [*8] ##1 pend_reg ##1 !pend_reg;
    endsequence

    // flag rises at the 11th edge, so it is sampled at the 12th
    a_frame_latency: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_take |-> ##12 s_result)
        else $error("result valid missing after start");

    a_valid_pulse: assert property (
        @(posedge core_clk) disable iff (!nrst)
        result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");

    a_outcome_one: assert property (
        @(posedge core_clk) disable iff (!nrst)
        result_valid |-> (not_tone != pe_test_required))
        else $error("outcome flags not exclusive");

    a_imag_negative: assert property (
        @(posedge core_clk) disable iff (!nrst)
        result_valid && pole_imag_term < 0 |-> not_tone)
        else $error("real poles not classed as not a tone");

    a_real_negative: assert property (
        @(posedge core_clk) disable iff (!nrst)
        result_valid && pole_imag_term >= 0 && pole_real_part < 0
        |-> pe_test_required)
        else $error("left half plane pole did not ask for test");

    a_ratio_low: assert property (
        @(posedge core_clk) disable iff (!nrst)
        result_valid && pole_imag_term >= 0 && pole_real_part >= 0
        |-> not_tone == $past(low_ratio))
        else $error("low ratio outcome wrong");

    a_real_calc: assert property (
        @(posedge core_clk) disable iff (!nrst)
        result_valid |-> pole_real_part == -($past(a1_w) >>> 1))
        else $error("real part not minus half of a1");

    a_energy_hold: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $past(state_reg) != ST_DONE |-> $stable(frame_energy))
        else $error("energy changed outside a result");

    a_walk_lags: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_take |-> ##2 s_walk)
        else $error("lag walk not nine products");

endmodule : frame_energy_and_pole_tone_test

/* testbench/encoder_model.sv */
/*
 * Encoder stand-in: lag pair loads and frame starts with coefficients.
 * Assumes core_clk comes from the bench and tb calls these tasks.
 */
`timescale 1ns/100ps

module encoder_model
    import frame_energy_pkg::*;
(
    input wire logic core_clk,
    output logic lag_load,
    output lag_idx_t lag_index,
    output sample_t signal_acf,
    output sample_t filter_acf,
    output logic frame_start,
    output sample_t coef_1,
    output sample_t coef_2
);
    // quiet lines at time zero
    initial begin
        lag_load = 1'b0;
        frame_start = 1'b0;
        lag_index = 4'h0;
        signal_acf = 16'sh0;
        filter_acf = 16'sh0;
        coef_1 = 16'sh0;
        coef_2 = 16'sh0;
    end

    // ==========================================================
    // one lag pair in one cycle; idle data is inverted, not held
    task automatic load_lag(input lag_idx_t i, input sample_t s,
        input sample_t f);
        @(posedge core_clk);
        #1;
        lag_load = 1'b1;
        lag_index = i;
        signal_acf = s;
        filter_acf = f;
        @(posedge core_clk);
        #1;
        lag_load = 1'b0;
        lag_index = ~i;
        signal_acf = ~s;
        filter_acf = ~f;
    endtask : load_lag

    // ==========================================================
    // first two coefficients, taken with the start pulse
    task automatic start_frame(input sample_t c1, input sample_t c2);
        @(posedge core_clk);
        #1;
        frame_start = 1'b1;
        coef_1 = c1;
        coef_2 = c2;
        @(posedge core_clk);
        #1;
        frame_start = 1'b0;
        coef_1 = ~c1;
        coef_2 = ~c2;
    endtask : start_frame
endmodule : encoder_model

/* testbench/tb.sv */
/*
 * Self-checking bench for the frame energy and pole tone test.
 * Assumes the encoder model drives every data input of the dut.
 */
`timescale 1ns/100ps
`include "frame_energy_map.svh"

module tb;
    import frame_energy_pkg::*;

    logic core_clk;
    logic nrst;
    logic lag_load;
    logic frame_start;
    logic busy;
    logic result_valid;
    logic not_tone;
    logic pe_test_required;
    lag_idx_t lag_index;
    sample_t signal_acf;
    sample_t filter_acf;
    sample_t coef_1;
    sample_t coef_2;
    acc_t frame_energy;
    logic signed [17:0] pole_real_part;
    logic signed [37:0] pole_imag_term;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    longint sig_v[`NUM_LAGS];
    longint flt_v[`NUM_LAGS];

    encoder_model enc (.core_clk(core_clk), .lag_load(lag_load),
        .lag_index(lag_index), .signal_acf(signal_acf),
        .filter_acf(filter_acf), .frame_start(frame_start),
        .coef_1(coef_1), .coef_2(coef_2));

    frame_energy_and_pole_tone_test dut (.core_clk(core_clk),
        .nrst(nrst), .lag_load(lag_load), .lag_index(lag_index),
        .signal_acf(signal_acf), .filter_acf(filter_acf),
        .frame_start(frame_start), .reflection_coefficient_1(coef_1),
        .reflection_coefficient_2(coef_2), .busy(busy),
        .result_valid(result_valid), .frame_energy(frame_energy),
        .not_tone(not_tone), .pe_test_required(pe_test_required),
        .pole_real_part(pole_real_part),
        .pole_imag_term(pole_imag_term));

    // ==========================================================
    // 5 ns clock; a hang past the ceiling ends the run
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check_acc(input acc_t got, input longint exp,
        input string msg);
        total_checks++;
        if (got !== acc_t'(exp)) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check_acc

    task automatic check_bit(input logic got, input logic exp,
        input string msg);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check_bit

    // bounded wait; n counts edges after the start edge
    task automatic wait_result(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (result_valid !== 1'b1 && n < 40);
    endtask : wait_result

    function automatic longint exp_energy();
        longint e;
        e = flt_v[0] * sig_v[0];
        for (int i = 1; i < `NUM_LAGS; i++) begin
            e += 2 * flt_v[i] * sig_v[i];
        end
        return e;
    endfunction : exp_energy

    // ==========================================================
    // lags loaded, one rewritten, index 9 dropped
    task automatic test_energy;
        int n;
        for (int i = 0; i < `NUM_LAGS; i++) begin
            sig_v[i] = 1200 - 310 * i;
            flt_v[i] = 250 * i - 900;
            enc.load_lag(lag_idx_t'(i), sample_t'(sig_v[i]),
                sample_t'(flt_v[i]));
        end
        sig_v[3] = 777;
        flt_v[3] = -555;
        enc.load_lag(4'h3, 16'sh0309, -16'sh022b);
        enc.load_lag(4'h9, 16'sh7fff, 16'sh7fff);
        enc.start_frame(16'sh0, 16'sh0);
        wait_result(n);
        check_acc(acc_t'(n), 11, "latency"); // result timing
        check_acc(frame_energy, exp_energy(), "energy"); // lag sum
    endtask : test_energy

    // each frame start is taken at the second edge after the previous result edge
    task automatic test_pole(input sample_t c1, input sample_t c2);
        longint a1;
        longint imag_v;
        longint real_v;
        logic nt;
        int n;
        // a1 in Q15, floored like a right shift
        a1 = (longint'(c1) * 32768 + longint'(c1) * c2) >>> 15;
        imag_v = longint'(c2) * 131072 - a1 * a1;
        real_v = -(a1 >>> 1);
        nt = imag_v < 0 ? 1'b1 : real_v < 0 ? 1'b0 :
            (imag_v * 32768 < `LOW_RATIO_Q15 * a1 * a1);
        enc.start_frame(c1, c2);
        wait_result(n);
        check_acc(acc_t'(n), 11, "pole latency"); // back to back
        check_acc(pole_real_part, real_v, "real part"); // real part
        check_acc(pole_imag_term, imag_v >>> 2, "imag term"); // imag
        check_bit(not_tone, nt, "not tone"); // verdict
        check_bit(pe_test_required, !nt, "pe test"); // other
        check_bit(busy, 1'b0, "busy at result"); // done
        check_acc(frame_energy, exp_energy(), "energy held"); // kept
    endtask : test_pole

    // load and start while running are both dropped
    task automatic test_refused;
        int n;
        enc.start_frame(16'sh2000, 16'sh4000);
        check_bit(busy, 1'b1, "busy in run"); // running
        enc.load_lag(4'h0, 16'sh7000, 16'sh7000);
        enc.start_frame(16'sh4000, 16'sh0);
        wait_result(n);
        check_acc(frame_energy, exp_energy(), "load in run"); // frame
        check_bit(not_tone, 1'b0, "second start"); // first kept
        @(posedge core_clk);
        #1;
        check_bit(result_valid, 1'b0, "pulse width"); // one pulse
        repeat (15) @(posedge core_clk);
        #1;
        check_bit(result_valid, 1'b0, "extra result"); // single
    endtask : test_refused

    // ==========================================================
    // reset, then the scenarios in turn
    initial begin
        nrst = 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        @(posedge core_clk);
        #1;
        check_acc(frame_energy, 0, "energy at reset"); // cleared
        check_bit(result_valid | busy | not_tone, 1'b0, "flags");
        test_energy(); // lag energy
        test_pole(16'sh4000, 16'sh0); // real poles
        test_pole(16'sh2000, 16'sh4000); // left half plane
        test_pole(-16'sh3c00, 16'sh0800); // low frequency
        test_pole(-16'sh1000, 16'sh0800); // ratio fails
        test_refused(); // refused requests
        end_of_test();
    end
endmodule : tb
